// File: src/asp_pkg.sv
// Purpose: shared constants and types for the serial command port
// Assumes: core_clk at 200 MHz, synchronous active-high reset
// Notes: registers are nine bits, bit 0 is the row parity
// Notes on behaviour
// - Select pin is always an input; a pull-up keeps it high when undriven. No pull-up here: the select sync only resets high.
// - Data pin outputs received data while select high; input, or output in read result. Here undriven with select high while type 1x is selected.
// - Result frame gives seven dummy bits, eight data bits, then the parity bit.
// - Select-high gap counts as one clock; data begins at the eighth clock after it.
// - Frame is 3-bit command, 4-bit address, data byte, parity, MSB first.
// - Clock idles low; sample on rising edge, change output on falling edge.
// - Clock count while select low must be exactly 16, else abort.
// - Command 000 turns on clamps of channels disabled in register 0.
// - Command 001 turns off the clamps of all channels.
// - Command 010 enters sleep; any other valid command wakes the device.
// - Command 011 holds gain level; command 100 returns gain to tracking.
// - Command 101 triggers a soft reset of internal blocks.
// - Command 110 reads registers 0 to 7; status parity position is don't-care.
// - Command 111 writes byte and parity; writes to status are ignored.
// - Address 0110 is the column parity byte, readable and writable.
// - Output type 00 demodulated data, 01 carrier clock, 1x signal strength.
// - Discharge switch acts only while signal-strength output is selected.
// - Soft reset is ignored unless the device is in active mode.
// - Soft reset during clamp-on keeps the clamp on.
// - Signal-strength output is suspended during a serial transfer, then resumes.
package asp_pkg;
  localparam int REG_WIDTH = 9;
  localparam int ADDR_WIDTH = 4;
  localparam int FRAME_BITS = 16;
  localparam int REG_COUNT = 8;
  localparam logic [3:0] ADDR_GENERAL = 4'h0;
  localparam logic [3:0] ADDR_X_TUNE = 4'h1;
  localparam logic [3:0] ADDR_Y_TUNE = 4'h2;
  localparam logic [3:0] ADDR_Z_TUNE = 4'h3;
  localparam logic [3:0] ADDR_XY_SENS = 4'h4;
  localparam logic [3:0] ADDR_Z_SENS = 4'h5;
  localparam logic [3:0] ADDR_COLUMN = 4'h6;
  localparam logic [3:0] ADDR_STATE = 4'h7;
  localparam logic [8:0] REG_RESET = 9'h000;
  localparam int CH_X_EN_BIT = 1;
  localparam int CH_Y_EN_BIT = 2;
  localparam int CH_Z_EN_BIT = 3;
  localparam int OUT_TYPE_HI = 8;
  localparam int OUT_TYPE_LO = 7;
  localparam int DISCHARGE_BIT = 8;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 13;
  localparam int ADDR_HI = 12;
  localparam int ADDR_LO = 9;
  localparam int DATA_HI = 8;
  localparam int DUMMY_BITS = 7;
  localparam logic [4:0] RESULT_START = 5'h07;
  typedef enum logic [2:0] {
    CMD_CLAMP_ON   = 3'h0,
    CMD_CLAMP_OFF  = 3'h1,
    CMD_SLEEP      = 3'h2,
    CMD_GAIN_HOLD  = 3'h3,
    CMD_GAIN_TRACK = 3'h4,
    CMD_SOFT_RESET = 3'h5,
    CMD_READ       = 3'h6,
    CMD_WRITE      = 3'h7
  } asp_cmd_type;
  typedef enum logic [1:0] {
    OUT_DEMOD   = 2'h0,
    OUT_CARRIER = 2'h1
  } asp_out_type;
endpackage : asp_pkg

// File: src/asp_reg_if.sv
// Purpose: register file access bundle
// Assumes: same clock on both sides
// Notes: one write port, one read port
`timescale 1ns/1ps
`default_nettype none
interface asp_reg_if;
  logic       writeEn;
  logic [3:0] writeAddr;
  logic [8:0] writeData;
  logic [3:0] readAddr;
  logic [8:0] readData;
  logic [8:0] generalReg;
  logic [8:0] xTuneReg;
  logic [8:0] yTuneReg;
  modport ctrl (output writeEn, output writeAddr, output writeData, output readAddr,
                input readData, input generalReg, input xTuneReg, input yTuneReg);
  modport store (input writeEn, input writeAddr, input writeData, input readAddr,
                 output readData, output generalReg, output xTuneReg, output yTuneReg);
endinterface : asp_reg_if
`default_nettype wire

// File: src/asp_reg_file.sv
// Purpose: seven nine-bit configuration registers plus the status word, with registered read
// Assumes: status word supplied from outside
// Notes: power-on clear of every register
`timescale 1ns/1ps
`default_nettype none
module asp_reg_file (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [8:0] statusWord,
  asp_reg_if.store        regs
);
  import asp_pkg::*;
  logic [8:0] mem_reg [0:REG_COUNT-2];
  genvar g;
  generate
    for (g = 0; g < REG_COUNT - 1; g++) begin : gen_cfg
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          mem_reg[g] <= REG_RESET;
        end else if (regs.writeEn && regs.writeAddr == 4'(g)) begin
          mem_reg[g] <= regs.writeData;
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs.readData <= REG_RESET;
    end else if (regs.readAddr == ADDR_STATE) begin
      regs.readData <= statusWord;
    end else if (regs.readAddr[3]) begin
      regs.readData <= REG_RESET;
    end else begin
      regs.readData <= mem_reg[regs.readAddr[2:0]];
    end
  end
  assign regs.generalReg = mem_reg[ADDR_GENERAL[2:0]];
  assign regs.xTuneReg   = mem_reg[ADDR_X_TUNE[2:0]];
  assign regs.yTuneReg   = mem_reg[ADDR_Y_TUNE[2:0]];
endmodule : asp_reg_file
`default_nettype wire

// File: src/asp_sync.sv
// Purpose: three-stage input synchroniser
// Assumes: asynchronous input
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module asp_sync (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic resetValue,
  input  wire logic pinIn,
  output logic      syncOut
);
  logic [2:0] stage_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // Start at the pin's idle level so no false edge follows reset
      stage_reg <= {3{resetValue}};
      syncOut   <= resetValue;
    end else begin
      stage_reg <= {stage_reg[1:0], pinIn};
      if (stage_reg[2] == stage_reg[1]) begin
        syncOut <= stage_reg[2];
      end
    end
  end
endmodule : asp_sync
`default_nettype wire

// File: src/asp_command_port.sv
// Purpose: serial slave port and command decoder
// Assumes: master follows mode 0,0 framing; link clock far slower than core_clk
// Notes: pin edges are found by sampling; clamp, sleep and gain are levels out, reset is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module asp_command_port (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       selectN,
  input  wire logic       serialClk,
  input  wire logic       dataIn,
  output logic            dataOut,
  output logic            dataOe,
  input  wire logic       demodData,
  input  wire logic       carrierClk,
  input  wire logic       activeMode,
  input  wire logic [8:0] statusWord,
  output logic [2:0]      clampOn,
  output logic            sleepMode,
  output logic            gainHold,
  output logic            softReset,
  output logic            strengthEnable,
  output logic            dischargeOn,
  output asp_pkg::asp_out_type outputMode,
  output logic [1:0]      outputType
);
  import asp_pkg::*;

  asp_reg_if regs ();
  logic selSync;
  logic clkSync;
  logic datSync;
  logic selPrev_reg;
  logic clkPrev_reg;
  logic [4:0] bitCount_reg;
  logic [15:0] shift_reg;
  logic readPending_reg;
  logic resultPhase_reg;
  logic [15:0] result_reg;
  logic driveBit_reg;
  logic [2:0] lastCmd;

  // Select idles high: its sync resets to 1, but a floating pin is not pulled up here
  asp_sync u_sel (.core_clk(core_clk), .sys_rst(sys_rst), .resetValue(1'b1),
                  .pinIn(selectN), .syncOut(selSync));
  asp_sync u_clk (.core_clk(core_clk), .sys_rst(sys_rst), .resetValue(1'b0),
                  .pinIn(serialClk), .syncOut(clkSync));
  asp_sync u_dat (.core_clk(core_clk), .sys_rst(sys_rst), .resetValue(1'b0),
                  .pinIn(dataIn), .syncOut(datSync));
  asp_reg_file u_regs (.core_clk(core_clk), .sys_rst(sys_rst),
                       .statusWord(statusWord), .regs(regs));

  // Select sync resets high, its idle level, so reset makes no select edge
  wire selLow  = ~selSync;
  wire selFall = selPrev_reg & ~selSync;
  wire selRise = ~selPrev_reg & selSync;
  wire clkRise = ~clkPrev_reg & clkSync;
  wire clkFall = clkPrev_reg & ~clkSync;
  wire frameOk = (bitCount_reg == 5'h10) && !resultPhase_reg;

  function automatic logic oddParity(input logic [8:0] w);
    oddParity = ^w;
  endfunction : oddParity

  assign lastCmd = shift_reg[CMD_HI:CMD_LO];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selPrev_reg <= 1'b1;
      clkPrev_reg <= 1'b0;
    end else begin
      selPrev_reg <= selSync;
      clkPrev_reg <= clkSync;
    end
  end

  // Bit counter and input shifter; rising edge samples, MSB first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bitCount_reg <= 5'h00;
      shift_reg    <= 16'h0000;
    end else if (selFall) begin
      bitCount_reg <= 5'h00;
    end else if (selLow && clkRise) begin
      shift_reg <= {shift_reg[14:0], datSync};
      // Count saturates past one frame: a longer burst can never match
      if (bitCount_reg != 5'h1F) begin
        bitCount_reg <= bitCount_reg + 5'h01;
      end
    end
  end

  // Register write only on select rise after a full frame
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs.writeEn   <= 1'b0;
      regs.writeAddr <= 4'h0;
      regs.writeData <= REG_RESET;
    end else begin
      regs.writeEn <= selRise && frameOk && lastCmd == CMD_WRITE &&
                      shift_reg[ADDR_HI:ADDR_LO] != ADDR_STATE;
      regs.writeAddr <= shift_reg[ADDR_HI:ADDR_LO];
      regs.writeData <= shift_reg[DATA_HI:0];
    end
  end

  // Read two-phase sequence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      readPending_reg <= 1'b0;
      resultPhase_reg <= 1'b0;
      regs.readAddr   <= 4'h0;
    end else if (selRise) begin
      resultPhase_reg <= 1'b0;
      readPending_reg <= frameOk && lastCmd == CMD_READ;
      if (frameOk && lastCmd == CMD_READ) begin
        regs.readAddr <= shift_reg[ADDR_HI:ADDR_LO];
      end
    end else if (selFall && readPending_reg) begin
      resultPhase_reg <= 1'b1;
      readPending_reg <= 1'b0;
    end
  end

  // Result shifter: dummy bits, data byte, parity; update on falling edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_reg   <= 16'h0000;
      driveBit_reg <= 1'b0;
    end else if (selFall && readPending_reg) begin
      result_reg   <= {{DUMMY_BITS{1'b0}}, regs.readData};
      driveBit_reg <= 1'b0;
    end else if (resultPhase_reg && selLow && clkFall) begin
      driveBit_reg <= result_reg[15];
      result_reg   <= {result_reg[14:0], 1'b0};
    end
  end

  // Command execution on completed frames
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clampOn   <= 3'h0;
      sleepMode <= 1'b0;
      gainHold  <= 1'b0;
      softReset <= 1'b0;
    end else begin
      softReset <= 1'b0;
      if (selRise && frameOk) begin
        sleepMode <= (lastCmd == CMD_SLEEP);
        unique case (lastCmd)
          CMD_CLAMP_ON: begin
            clampOn <= ~{regs.generalReg[CH_Z_EN_BIT], regs.generalReg[CH_Y_EN_BIT],
                         regs.generalReg[CH_X_EN_BIT]};
          end
          CMD_CLAMP_OFF: begin
            clampOn <= 3'h0;
          end
          CMD_SLEEP: begin
          end
          CMD_GAIN_HOLD: begin
            gainHold <= 1'b1;
          end
          CMD_GAIN_TRACK: begin
            gainHold <= 1'b0;
          end
          CMD_SOFT_RESET: begin
            // Clamp state deliberately untouched by the pulse
            softReset <= activeMode;
          end
          CMD_READ: begin
          end
          CMD_WRITE: begin
          end
        endcase
      end
    end
  end

  assign outputType = regs.xTuneReg[OUT_TYPE_HI:OUT_TYPE_LO];
  wire strengthSel = outputType[1];

  always_comb begin
    outputMode     = asp_out_type'(outputType[0] ? OUT_CARRIER : OUT_DEMOD);
    strengthEnable = strengthSel && !selLow;
    dischargeOn    = strengthSel && regs.yTuneReg[DISCHARGE_BIT];
  end

  // Pad: drive data while select high (non-strength), or in read result
  always_comb begin
    if (!selLow) begin
      dataOe  = !strengthSel;
      dataOut = outputType[0] ? carrierClk : demodData;
    end else if (resultPhase_reg) begin
      dataOe  = 1'b1;
      dataOut = driveBit_reg;
    end else begin
      dataOe  = 1'b0;
      dataOut = 1'b0;
    end
  end

  wire unusedParity = oddParity(shift_reg[8:0]);
endmodule : asp_command_port
`default_nettype wire

// File: tb/asp_chk.sv
// Purpose: port-level checker for the serial command port
// Assumes: select seen through a three-stage sync, so six idle cycles settle it
// Notes: attached by bind after the module
`timescale 1ns/1ps
`default_nettype none
module asp_chk (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 selectN,
  input wire logic                 serialClk,
  input wire logic                 dataOut,
  input wire logic                 dataOe,
  input wire logic                 demodData,
  input wire logic                 carrierClk,
  input wire logic                 activeMode,
  input wire logic [2:0]           clampOn,
  input wire logic                 sleepMode,
  input wire logic                 gainHold,
  input wire logic                 softReset,
  input wire logic                 strengthEnable,
  input wire logic                 dischargeOn,
  input wire asp_pkg::asp_out_type outputMode,
  input wire logic [1:0]           outputType
);
  import asp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence selIdle; selectN [*6]; endsequence
  sequence selBusy; !selectN [*8]; endsequence
  demod_route_a: assert property (selIdle ##0 outputType == 2'h0 |-> dataOe && dataOut == demodData)
    else $error("demod data not on pad");
  carrier_route_a: assert property (selIdle ##0 outputType == 2'h1 |-> dataOe && dataOut == carrierClk)
    else $error("carrier clock not on pad");
  mode_map_a: assert property (!outputType[1] |-> outputMode == asp_out_type'(outputType))
    else $error("output mode mismatch");
  discharge_gate_a: assert property (dischargeOn |-> outputType[1])
    else $error("discharge outside strength mode");
  strength_off_a: assert property (selBusy |-> !strengthEnable)
    else $error("strength output during transfer");
  strength_on_a: assert property (selIdle ##0 outputType[1] |-> strengthEnable)
    else $error("strength output not resumed");
  reset_pulse_a: assert property (softReset |-> activeMode ##1 !softReset)
    else $error("soft reset pulse wrong");
  // Effects land only after select rises, never mid-frame
  frame_quiet_a: assert property (selBusy |-> $stable(clampOn) && $stable(sleepMode) && $stable(gainHold) && $stable(outputType))
    else $error("state changed inside frame");
  fall_change_a: assert property ($changed(dataOut) && dataOe && $past(dataOe) && !selectN |-> !serialClk)
    else $error("result bit moved with clock high");
endmodule : asp_chk
bind asp_command_port asp_chk asp_chk_inst (.core_clk, .sys_rst, .selectN, .serialClk, .dataOut,
  .dataOe, .demodData, .carrierClk, .activeMode, .clampOn, .sleepMode, .gainHold, .softReset,
  .strengthEnable, .dischargeOn, .outputMode, .outputType);
`default_nettype wire

// File: tb/asp_master_model.sv
// Purpose: behavioural serial master, mode 0,0, 125 ns link period
// Assumes: 12 high and 13 low core cycles per link clock
// Notes: released data line toggles so a stale value never passes
`timescale 1ns/1ps
`default_nettype none
module asp_master_model (
  input  wire logic core_clk,
  output logic      selectN,
  output logic      serialClk,
  output logic      dataIn,
  input  wire logic dataOut,
  input  wire logic dataOe
);
  initial begin
    selectN = 1'b1;
    serialClk = 1'b0;
    dataIn = 1'b0;
  end
  task automatic frame(input logic [15:0] tx, input int n, input logic drv, output logic [15:0] rx);
    rx = 16'h0000;
    selectN = 1'b0;
    dataIn = drv ? tx[15] : ~dataIn;
    repeat (13) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      serialClk = 1'b1;
      repeat (12) @(negedge core_clk);
      serialClk = 1'b0;
      repeat (6) @(negedge core_clk);
      // Undriven pad reads inverted, so a missing output enable is caught
      rx = {rx[14:0], dataOe ? dataOut : ~dataOut};
      dataIn = (drv && i < 15) ? tx[14 - i] : ~dataIn;
      repeat (7) @(negedge core_clk);
    end
    selectN = 1'b1;
    repeat (25) @(negedge core_clk);
  endtask : frame
endmodule : asp_master_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the serial command port
// Assumes: frame task ends after a select-high gap long enough for effects
// Notes: status parity position is masked, it is don't-care
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asp_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        selectN, serialClk, dataIn, dataOut, dataOe;
  logic        demodData = 1'b0;
  logic        carrierClk = 1'b0;
  logic        activeMode = 1'b1;
  logic [8:0]  statusWord = 9'h0A5;
  logic [2:0]  clampOn;
  logic        sleepMode, gainHold, softReset, strengthEnable, dischargeOn;
  asp_out_type outputMode;
  logic [1:0]  outputType;
  logic [15:0] rx;
  logic [8:0]  vals [7] = '{9'h002, 9'h001, 9'h0F1, 9'h07F, 9'h155, 9'h100, 9'h1AA};
  int          error_cnt = 0;
  int          checks_done = 0;
  int          pulses = 0;
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) {carrierClk, demodData} <= {carrierClk, demodData} + 2'h1;
  always @(negedge core_clk) if (softReset === 1'b1) pulses <= pulses + 1;
  asp_command_port asp_command_port_inst (.core_clk, .sys_rst, .selectN, .serialClk, .dataIn,
    .dataOut, .dataOe, .demodData, .carrierClk, .activeMode, .statusWord, .clampOn, .sleepMode,
    .gainHold, .softReset, .strengthEnable, .dischargeOn, .outputMode, .outputType);
  asp_master_model asp_master_model_inst (.core_clk, .selectN, .serialClk, .dataIn, .dataOut,
    .dataOe);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic send(input asp_cmd_type c, input logic [3:0] a, input logic [8:0] d, input int n);
    logic [15:0] r;
    asp_master_model_inst.frame({c, a, d}, n, 1'b1, r);
  endtask : send
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    send(CMD_READ, a, 9'h000, 16);
    asp_master_model_inst.frame(16'h0000, 16, 1'b0, r);
  endtask : rd
  task automatic print_verdict();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // Frames are bounded in length, so only a stuck simulation can hit this
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge core_clk);
    for (int i = 0; i < 7; i++) begin
      rd(4'(i), rx);
      check(rx, 16'h0000);
    end
    rd(ADDR_STATE, rx);
    check({rx[15:1], 1'b0}, {7'h00, statusWord[8:1], 1'b0});
    rd(4'h9, rx);
    check(rx, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) send(CMD_WRITE, 4'(i), vals[i], 16);
    for (int i = 0; i < 7; i++) begin
      rd(4'(i), rx);
      check(rx, {7'h00, vals[i]});
    end
    send(CMD_WRITE, ADDR_STATE, 9'h15A, 16);
    rd(ADDR_STATE, rx);
    check({rx[15:1], 1'b0}, {7'h00, statusWord[8:1], 1'b0});
    send(CMD_WRITE, ADDR_XY_SENS, 9'h001, 15);
    send(CMD_WRITE, ADDR_XY_SENS, 9'h001, 17);
    rd(ADDR_XY_SENS, rx);
    check(rx, {7'h00, vals[4]});
    $display("test write readback done");
    send(CMD_CLAMP_ON, 4'hF, 9'h1FF, 16);
    check({13'h0, clampOn}, 16'h0006);
    send(CMD_SOFT_RESET, 4'h0, 9'h000, 16);
    check({13'h0, clampOn}, 16'h0006);
    check(16'(pulses), 16'h0001);
    activeMode = 1'b0;
    send(CMD_SOFT_RESET, 4'h0, 9'h000, 16);
    check(16'(pulses), 16'h0001);
    activeMode = 1'b1;
    send(CMD_CLAMP_OFF, 4'h5, 9'h0AA, 16);
    check({13'h0, clampOn}, 16'h0000);
    send(CMD_SLEEP, 4'h0, 9'h000, 16);
    check({15'h0, sleepMode}, 16'h0001);
    send(CMD_GAIN_HOLD, 4'h0, 9'h000, 16);
    check({14'h0, sleepMode, gainHold}, 16'h0001);
    send(CMD_GAIN_TRACK, 4'h0, 9'h000, 16);
    check({15'h0, gainHold}, 16'h0000);
    $display("test commands done");
    send(CMD_WRITE, ADDR_X_TUNE, 9'h080, 16);
    send(CMD_WRITE, ADDR_Y_TUNE, 9'h100, 16);
    check({13'h0, outputType, dischargeOn}, 16'h0002);
    send(CMD_WRITE, ADDR_X_TUNE, 9'h100, 16);
    check({13'h0, outputType[1], dischargeOn, strengthEnable}, 16'h0007);
    send(CMD_WRITE, ADDR_X_TUNE, 9'h181, 16);
    check({14'h0, outputType}, 16'h0003);
    $display("test output select done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
